// ===== verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   // register addresses in the special function register space
   localparam logic [7:0] ADDR_CLK_DIV = 8'hF2;
   localparam logic [7:0] ADDR_CTRL = 8'hF3;
   localparam logic [7:0] ADDR_RES_LO = 8'hF4;
   localparam logic [7:0] ADDR_RES_HI = 8'hF5;
   localparam logic [7:0] ADDR_PIN_CFG = 8'hF6;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;
   // converter_control field positions
   localparam int CTRL_PRECISION_IDLE_SELECT_BIT = 6;
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_DONE_BIT = 4;
   localparam int CTRL_START_BIT = 3;
   localparam int CTRL_CHAN_MSB = 2;
   localparam int CHAN_W = 3;
   // converter_clock_divider field
   localparam int PRS_MSB = 4;
   localparam int PRS_W = 5;
   // bit of the second interrupt enable register that gates this source
   localparam int IEN_CONV_BIT = 1;
   // converter timing
   localparam int DIV_W = 7;
   localparam logic [DIV_W-1:0] DIV_FOR_ZERO = 7'h40;
   localparam int PER_W = 4;
   localparam logic [PER_W-1:0] CONV_PERIODS = 4'hB;
   localparam int RESULT_W = 10;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;
endpackage : adc_ctrl_pkg

// ===== verilog/adc_conversion_control.sv
`timescale 1ns/10ps
module adc_conversion_control (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire adc_ctrl_pkg::sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] second_irq_enable_reg,
   input wire logic [adc_ctrl_pkg::RESULT_W-1:0] core_result,
   output logic [7:0] pin_route_bits,
   output logic [adc_ctrl_pkg::CHAN_W-1:0] selected_analog_input,
   output logic converter_enable,
   output logic sample_hold,
   output logic conv_strobe,
   output logic cpu_halt,
   output logic irq_defer,
   output logic converter_irq
);
   import adc_ctrl_pkg::*;

   function automatic logic [DIV_W-1:0] conv_div(input logic [PRS_W-1:0] prs);
      conv_div = (prs == '0) ? DIV_FOR_ZERO : {1'b0, prs, 1'b0};
   endfunction : conv_div

   function automatic logic is_write(input sfr_req_t r, input logic [7:0] a);
      is_write = r.wr && (r.addr == a);
   endfunction : is_write

   logic [PRS_W-1:0] clk_div_q, clk_div_d;
   logic [7:0] pin_cfg_q, pin_cfg_d;
   logic precision_idle_select_q, precision_idle_select_d;
   logic enable_q, enable_d;
   logic done_q, done_d;
   logic start_q, start_d;
   logic [CHAN_W-1:0] chan_q, chan_d;
   logic [CHAN_W-1:0] conv_chan_q, conv_chan_d;
   logic prec_q, prec_d;
   logic [7:0] res_hi_q, res_hi_d;
   logic [1:0] res_lo_q, res_lo_d;
   conv_state_t state_q, state_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [DIV_W-1:0] pre_cnt_q, pre_cnt_d;
   logic [PER_W-1:0] per_cnt_q, per_cnt_d;
   logic [7:0] rdata_q, rdata_d;
   logic wr_ctrl, start_req, tick, conv_done, busy;
   logic [CHAN_W-1:0] wr_chan;

   assign busy = (state_q == ST_CONV);
   assign wr_ctrl = is_write(sfr_req, ADDR_CTRL);
   assign wr_chan = sfr_req.wdata[CTRL_CHAN_MSB:0];
   // unrouted pin or standby: the write leaves the start bit clear
   assign start_req = wr_ctrl && sfr_req.wdata[CTRL_START_BIT]
                      && sfr_req.wdata[CTRL_ENABLE_BIT]
                      && pin_cfg_q[wr_chan] && !busy;
   assign tick = busy && (pre_cnt_q == div_q - 7'h01);
   assign conv_done = tick && (per_cnt_q == CONV_PERIODS - 4'h1);

   // configuration and control bits
   always_comb begin
      clk_div_d = clk_div_q;
      pin_cfg_d = pin_cfg_q;
      precision_idle_select_d = precision_idle_select_q;
      enable_d = enable_q;
      chan_d = chan_q;
      if (is_write(sfr_req, ADDR_CLK_DIV)) begin
         clk_div_d = sfr_req.wdata[PRS_MSB:0];
      end
      if (is_write(sfr_req, ADDR_PIN_CFG)) begin
         pin_cfg_d = sfr_req.wdata;
      end
      if (wr_ctrl) begin
         precision_idle_select_d = sfr_req.wdata[CTRL_PRECISION_IDLE_SELECT_BIT];
         enable_d = sfr_req.wdata[CTRL_ENABLE_BIT];
         chan_d = wr_chan;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_div_q <= REG_RESET[PRS_W-1:0];
         pin_cfg_q <= REG_RESET;
         precision_idle_select_q <= 1'b0;
         enable_q <= 1'b0;
         chan_q <= REG_RESET[CHAN_W-1:0];
      end else begin
         clk_div_q <= clk_div_d;
         pin_cfg_q <= pin_cfg_d;
         precision_idle_select_q <= precision_idle_select_d;
         enable_q <= enable_d;
         chan_q <= chan_d;
      end
   end

   // conversion sequencer, flags and results
   always_comb begin
      state_d = state_q;
      start_d = start_q;
      prec_d = prec_q;
      conv_chan_d = conv_chan_q;
      div_d = div_q;
      pre_cnt_d = pre_cnt_q;
      per_cnt_d = per_cnt_q;
      res_hi_d = res_hi_q;
      res_lo_d = res_lo_q;
      // a done in the same cycle as a clearing write keeps the flag set
      done_d = done_q && !(wr_ctrl && !sfr_req.wdata[CTRL_DONE_BIT]);
      unique case (state_q)
         ST_IDLE: begin
            if (start_req) begin
               state_d = ST_CONV;
               start_d = 1'b1;
               prec_d = sfr_req.wdata[CTRL_PRECISION_IDLE_SELECT_BIT];
               conv_chan_d = wr_chan;
               div_d = conv_div(clk_div_q);
               pre_cnt_d = '0;
               per_cnt_d = '0;
            end
         end
         ST_CONV: begin
            pre_cnt_d = tick ? '0 : pre_cnt_q + 7'h01;
            if (tick) begin
               per_cnt_d = per_cnt_q + 4'h1;
            end
            if (!enable_d) begin
               // standby aborts: no result, no flag
               state_d = ST_IDLE;
               start_d = 1'b0;
               prec_d = 1'b0;
            end else if (conv_done) begin
               state_d = ST_IDLE;
               start_d = 1'b0;
               done_d = 1'b1;
               prec_d = 1'b0;
               // core code already saturated at the reference rails
               res_hi_d = core_result[RESULT_W-1:2];
               res_lo_d = core_result[1:0];
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         start_q <= 1'b0;
         done_q <= 1'b0;
         prec_q <= 1'b0;
         conv_chan_q <= '0;
         div_q <= DIV_FOR_ZERO;
         pre_cnt_q <= '0;
         per_cnt_q <= '0;
         res_hi_q <= REG_RESET;
         res_lo_q <= REG_RESET[1:0];
      end else begin
         state_q <= state_d;
         start_q <= start_d;
         done_q <= done_d;
         prec_q <= prec_d;
         conv_chan_q <= conv_chan_d;
         div_q <= div_d;
         pre_cnt_q <= pre_cnt_d;
         per_cnt_q <= per_cnt_d;
         res_hi_q <= res_hi_d;
         res_lo_q <= res_lo_d;
      end
   end

   // register read, answered one cycle after the read strobe
   always_comb begin
      rdata_d = READ_NONE;
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            ADDR_CLK_DIV: rdata_d = {3'h0, clk_div_q};
            ADDR_CTRL: rdata_d = {1'b0, precision_idle_select_q, enable_q, done_q, start_q, chan_q};
            ADDR_RES_LO: rdata_d = {6'h00, res_lo_q};
            ADDR_RES_HI: rdata_d = res_hi_q;
            ADDR_PIN_CFG: rdata_d = pin_cfg_q;
            default: rdata_d = READ_NONE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= READ_NONE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign pin_route_bits = pin_cfg_q;
   assign selected_analog_input = conv_chan_q;
   assign converter_enable = enable_q;
   assign sample_hold = busy && (per_cnt_q == '0);
   assign conv_strobe = tick;
   // processor halt ends when the conversion ends or aborts, whatever the interrupt enable
   assign cpu_halt = busy && prec_q;
   assign irq_defer = cpu_halt;
   assign converter_irq = done_q && second_irq_enable_reg[IEN_CONV_BIT];

   // checking helpers
   logic [10:0] conv_cyc_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cyc_q <= '0;
      end else begin
         conv_cyc_q <= busy ? conv_cyc_q + 11'h001 : '0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_chan_latch;
      start_req |=> selected_analog_input == $past(wr_chan) && busy;
   endproperty
   a_chan_latch: assert property (p_chan_latch) else $error("channel not latched");

   property p_start_clear;
      conv_done |=> !start_q && !busy;
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("start bit stuck");

   property p_flag_hold;
      done_q && !wr_ctrl |=> done_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

   property p_irq;
      converter_irq |-> $past(conv_done || done_q);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt mismatch");

   property p_route;
      is_write(sfr_req, ADDR_PIN_CFG) |=> pin_route_bits == $past(sfr_req.wdata);
   endproperty
   a_route: assert property (p_route) else $error("pin route not written");

   property p_no_effect;
      wr_ctrl && !busy && !pin_cfg_q[wr_chan] |=> !busy && !start_q;
   endproperty
   a_no_effect: assert property (p_no_effect) else $error("unrouted start acted");

   property p_halt;
      start_req && sfr_req.wdata[6] |=> cpu_halt && irq_defer until !busy;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not held");

   property p_length;
      conv_done |-> (32'(conv_cyc_q) + 1) == 11 * 32'(div_q);
   endproperty
   a_length: assert property (p_length) else $error("conversion length wrong");

   property p_standby;
      !enable_q |-> !busy;
   endproperty
   a_standby: assert property (p_standby) else $error("busy in standby");

   property p_result;
      conv_done && enable_d |=> done_q && !start_q
         && res_hi_q == $past(core_result[9:2]) && res_lo_q == $past(core_result[1:0]);
   endproperty
   a_result: assert property (p_result) else $error("result not updated");

   property p_cov_prec;
      conv_done && prec_q;
   endproperty
   c_cov_prec: cover property (p_cov_prec);

   property p_cov_std;
      conv_done && !prec_q;
   endproperty
   c_cov_std: cover property (p_cov_std);

   property p_cov_refused;
      wr_ctrl && sfr_req.wdata[3] && !start_req;
   endproperty
   c_cov_refused: cover property (p_cov_refused);
endmodule : adc_conversion_control

// ===== verification/conv_core_model.sv
`timescale 1ns/10ps
module conv_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] selected_analog_input,
   input wire logic sample_hold,
   input wire logic conv_strobe,
   input wire logic converter_enable,
   input wire logic signed [15:0] level_mv [8],
   output logic [9:0] core_result
);
   logic busy_q;
   logic [3:0] cnt_q;
   logic [9:0] junk_q;
   int mv;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         junk_q <= 10'h155;
      end else begin
         junk_q <= ~junk_q + 10'h001;
         if (!converter_enable) begin
            busy_q <= 1'b0;
         end else if (!busy_q && sample_hold) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
         end else if (busy_q && conv_strobe) begin
            cnt_q <= cnt_q + 4'h1;
            busy_q <= (cnt_q != 4'hA); // eleven periods per conversion
         end
      end
   end
   // outside a conversion the code is meaningless, so it keeps moving
   always_comb begin
      mv = level_mv[selected_analog_input];
      if (!busy_q) core_result = junk_q;
      else if (mv >= 3000) core_result = 10'h3FF; // saturate high
      else if (mv <= 0) core_result = 10'h000; // saturate low
      else core_result = 10'(mv * 1023 / 3000); // linear
   end
endmodule : conv_core_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import adc_ctrl_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   sfr_req_t sfr_req;
   logic [7:0] sfr_rdata, ien, pin_route_bits, rv, last_lo;
   logic [9:0] core_result;
   logic [2:0] selected_analog_input;
   logic converter_enable, sample_hold, conv_strobe, cpu_halt, irq_defer, converter_irq;
   logic signed [15:0] level_mv [8];
   integer seed = 32'h261305C1;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   always #4 sys_clk = ~sys_clk;
   adc_conversion_control adc_conversion_control_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .second_irq_enable_reg(ien),
      .core_result(core_result), .pin_route_bits(pin_route_bits),
      .selected_analog_input(selected_analog_input), .converter_enable(converter_enable),
      .sample_hold(sample_hold), .conv_strobe(conv_strobe), .cpu_halt(cpu_halt),
      .irq_defer(irq_defer), .converter_irq(converter_irq));
   conv_core_model conv_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .selected_analog_input(selected_analog_input), .sample_hold(sample_hold),
      .conv_strobe(conv_strobe), .converter_enable(converter_enable),
      .level_mv(level_mv), .core_result(core_result));
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // a spare cycle after each access keeps strobes from being rewritten in one step
   task automatic wr(logic [7:0] a, logic [7:0] d);
      sfr_req.addr = a;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      @(negedge sys_clk);
      sfr_req.wr = 1'b0;
      @(negedge sys_clk);
   endtask : wr
   task automatic rdchk(string n, logic [7:0] a, logic [7:0] exp);
      sfr_req.addr = a;
      sfr_req.rd = 1'b1;
      @(negedge sys_clk);
      sfr_req.rd = 1'b0;
      rv = sfr_rdata;
      chk(n, rv, exp);
      @(negedge sys_clk);
   endtask : rdchk
   function automatic logic [9:0] code_of(int mv);
      if (mv >= 3000) return 10'h3FF;
      if (mv <= 0) return 10'h000;
      return 10'(mv * 1023 / 3000);
   endfunction : code_of
   task automatic conv(logic [2:0] ch, logic [4:0] prs, logic ps);
      int n;
      int dv;
      logic [7:0] cfg;
      logic [9:0] c;
      dv = (prs == 5'h00) ? 64 : 2 * prs;
      c = code_of(level_mv[ch]);
      cfg = $random(seed) | (8'h01 << ch);
      wr(ADDR_PIN_CFG, cfg);
      chk("route", pin_route_bits, cfg);
      wr(ADDR_CLK_DIV, {3'h7, prs});
      rdchk("div", ADDR_CLK_DIV, {3'h0, prs});
      wr(ADDR_CTRL, {1'b0, ps, 3'h5, ch});
      chk("halt", cpu_halt, ps);
      chk("defer", irq_defer, ps);
      chk("chan", selected_analog_input, ch);
      n = 0;
      while (converter_irq !== 1'b1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      // wr returns one edge after the start edge, so that edge is added back
      chk("latency", n + 1, 11 * dv);
      chk("halt end", cpu_halt, 1'b0);
      rdchk("ctrl", ADDR_CTRL, {1'b0, ps, 3'h6, ch});
      rdchk("hi", ADDR_RES_HI, c[9:2]);
      last_lo = {6'h00, c[1:0]};
      rdchk("lo", ADDR_RES_LO, last_lo);
      ien = 8'h00;
      @(negedge sys_clk);
      chk("masked", converter_irq, 1'b0);
      ien = 8'h02;
      @(negedge sys_clk);
      chk("irq", converter_irq, 1'b1);
      wr(ADDR_CTRL, {1'b0, ps, 3'h4, ch});
      chk("rearm", converter_irq, 1'b0);
   endtask : conv
   initial begin
      sfr_req = '0;
      ien = 8'h02;
      foreach (level_mv[i]) level_mv[i] = 16'($random(seed) % 1800 + 1500);
      level_mv[0] = 16'sd3500;
      level_mv[7] = -16'sd100;
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      for (int i = 0; i < 5; i++)
         rdchk("rst", ADDR_CLK_DIV + 8'(i), REG_RESET);
      rdchk("unmapped", 8'hF0, 8'h00);
      wr(ADDR_CTRL, 8'h20);
      repeat (500) @(negedge sys_clk); // settle time after enable
      for (int i = 0; i < 8; i++)
         conv(3'(i), (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : 5'($random(seed)), i % 3 == 2);
      wr(ADDR_RES_LO, 8'hFF);
      rdchk("ro", ADDR_RES_LO, last_lo);
      wr(ADDR_PIN_CFG, 8'hDF);
      wr(ADDR_CLK_DIV, 8'h01);
      wr(ADDR_CTRL, 8'h2D);
      repeat (30) @(negedge sys_clk);
      rdchk("unrouted", ADDR_CTRL, 8'h25);
      wr(ADDR_CTRL, 8'h08);
      rdchk("standby", ADDR_CTRL, 8'h00);
      chk("standby pin", converter_enable, 1'b0);
      wr(ADDR_CTRL, 8'h20);
      chk("enable pin", converter_enable, 1'b1);
      repeat (500) @(negedge sys_clk); // settle again before the next start
      wr(ADDR_CTRL, 8'h28);
      repeat (5) @(negedge sys_clk);
      wr(ADDR_CTRL, 8'h00);
      repeat (30) @(negedge sys_clk);
      rdchk("abort", ADDR_CTRL, 8'h00);
      chk("abort irq", converter_irq, 1'b0);
      give_verdict();
   end
endmodule : tb_top
